// ==== logic/dma_transfer_registers.sv ====
// DMA interface register set, counters and data buffers
//
// What this block does
// R1 - Transfer count: 16-bit RW, negative word count
// R2 - Count advances per transfer when allowed
// R3 - Count reaching zero stops, readies, interrupts
// R4 - Transfer count accepts word accesses only
// R5 - Memory address: 15-bit RW word address
// R6 - Address advances per transfer when allowed
// R7 - Address carry bumps extended or upper bits
// R8 - Sixteen-bit systems wrap to zero
// R9 - Upper address: 6-bit, 22-bit mode, words
// R10 - Control bit 00 writes, reads zero
// R11 - Control bits RW versus read-only split
// R12 - Control bit 14 cleared by writing zero
// R13 - Extended bits writable only in 18-bit mode
// R14 - Control register allows byte and word access
// R15 - Input buffer read-only, output buffer write-only
// R16 - Buffers move by DMA or processor access
// R17 - Buffers share one address by direction
// R18 - Looped connectors act as one register
// R19 - Second address read returns upper address
// R20 - Request rising edge starts one DMA, none while the memory FIFO is full
// R21 - User holds address allow high normally
// R22 - Bus address is upper (22-bit mode) or extended bits, address, zero
`timescale 1ns/1ps
module dma_transfer_registers
  import dma_regs_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input  wire logic                    clk,                // System clock
  input  wire logic                    rst,                // Bus initialise
  input  wire dma_regs_pkg::host_req_s host_req,           // Host register access
  output logic                  [15:0] host_rdata,         // Read data, registered
  input  wire logic                    addr22_mode,        // 22-bit addressing strap
  input  wire logic                    addr16_system,      // Only 16 address bits
  input  wire logic             [15:0] user_data_in,       // Input connector data
  input  wire logic              [2:0] user_status,        // User status lines
  input  wire logic                    user_attention,     // User attention line
  input  wire logic                    cycle_request,      // Transfer request pin
  input  wire logic                    count_advance_allow, // Count increment enable
  input  wire logic                    address_advance_allow, // Address increment enable
  input  wire logic                    dma_to_memory,      // Direction: input buffer out
  output logic                  [15:0] user_data_out,      // Output connector data
  output logic                   [2:0] user_function,      // Function lines
  output logic                         ready_out,          // Ready flag
  output logic                         irq,                // Interrupt request level
  output logic                         dma_req,            // DMA request pending
  input  wire logic                    dma_done,           // Bus finished one transfer
  input  wire logic             [15:0] dma_rdata,          // Word read from memory
  output dma_regs_pkg::mem_word_s      mem_out,            // Address/data to memory
  output logic                         mem_out_valid,      // Memory write word ready
  input  wire logic                    mem_out_ready       // Memory side accepts
);
  import dma_regs_pkg::*;

  logic [15:0] transfer_count_reg;
  logic [14:0] memory_address;
  logic [5:0]  upper_address_reg;
  logic [15:0] control_status_reg;
  logic [15:0] data_buffer_reg;
  logic [15:0] input_capture;
  logic        second_read;
  logic        ready_q;
  logic        irq_q;
  logic        req_q;
  logic        active;
  logic [1:0]  req_sync;
  logic        req_last;
  logic [15:0] in_sync1;
  logic [15:0] in_sync2;
  logic [2:0]  stat_sync1;
  logic [2:0]  stat_sync2;
  logic [1:0]  attn_sync;
  logic [1:0]  cnt_sync;
  logic [1:0]  adr_sync;

  // Pins from the user device are asynchronous
  always_ff @(posedge clk)
  begin
    in_sync1   <= user_data_in;
    in_sync2   <= in_sync1;
    stat_sync1 <= user_status;
    stat_sync2 <= stat_sync1;
    attn_sync  <= {attn_sync[0], user_attention};
    cnt_sync   <= {cnt_sync[0], count_advance_allow};
    adr_sync   <= {adr_sync[0], address_advance_allow};
    req_sync   <= {req_sync[0], cycle_request};
    req_last   <= req_sync[1];
  end

  // Host decode
  wire wr_any    = host_req.wr;
  wire rd_any    = host_req.rd;
  wire word_acc  = (host_req.byte_en == 2'b11);
  wire wr_count  = wr_any && (host_req.index == REG_COUNT) && word_acc;    // [R4]
  wire hit_addr  = host_req.index == REG_ADDRESS;
  wire wr_addr   = wr_any && hit_addr && word_acc && !second_read;
  wire wr_upper  = wr_any && hit_addr && word_acc && second_read && addr22_mode; // [R9]
  wire wr_ctrl   = wr_any && (host_req.index == REG_CONTROL);             // [R14]
  wire wr_data   = wr_any && (host_req.index == REG_DATA);                // [R17]
  wire rd_addr   = rd_any && hit_addr;

  // Byte lanes of a control write
  wire [15:0] lane_mask = {{8{host_req.byte_en[1]}}, {8{host_req.byte_en[0]}}};
  wire [15:0] xa_wmask  = addr22_mode ? 16'h0000 : CS_XA_MASK;            // [R13]
  wire [15:0] ctrl_wm   = lane_mask & ((CS_RW_MASK & ~CS_XA_MASK) | xa_wmask); // [R11]

  // Rising edge of the request pin
  wire req_edge   = req_sync[1] && !req_last;                              // [R20]
  wire go_write   = wr_ctrl && host_req.byte_en[0] && host_req.wdata[CS_GO]; // [R10]
  wire attn_stop  = attn_sync[1];

  // Transfer completion and counting
  wire        xfer       = active && req_q && dma_done;
  wire        cnt_step   = xfer && cnt_sync[1];                            // [R2]
  wire [15:0] count_next = transfer_count_reg + 16'h0001;
  wire        count_zero = cnt_step && (count_next == 16'h0000);            // [R3]
  wire        adr_step   = xfer && adr_sync[1];                             // [R6]
  wire [15:0] addr_sum   = {1'b0, memory_address} + 16'h0001;
  wire        addr_carry = adr_step && addr_sum[15];                        // [R7]
  wire [1:0]  xa_now     = control_status_reg[CS_XA_HI:CS_XA_LO];
  // A 16-bit system ignores the extended bits, so it wraps to zero
  wire [1:0]  xa_next    = addr16_system ? 2'b00 : xa_now + 2'b01;          // [R8]

  // Words bound for memory go through the FIFO; a request edge while it is full is dropped
  logic fifo_in_ready;
  wire  [37:0] fifo_word = {upper_address_reg, xa_now[1:0] & {2{!addr22_mode}},
                            memory_address[13:0], data_buffer_reg};
  mem_word_s push_word;
  assign push_word.addr = addr22_mode ? {upper_address_reg, memory_address, 1'b0} // [R22]
                                      : {4'h0, xa_now, memory_address, 1'b0};
  assign push_word.data = input_capture;                                    // [R16]
  wire fifo_push = xfer && dma_to_memory;
  wire [37:0] fifo_out;

  word_fifo #(.WIDTH(38), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst       (rst),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (mem_out_valid),
    .out_ready (mem_out_ready),
    .out_data  (fifo_out)
  );
  assign mem_out = fifo_out;

  // Control/status read view
  wire [15:0] ctrl_view = {control_status_reg[15], control_status_reg[14], attn_sync[1],
                           control_status_reg[12], stat_sync2,
                           control_status_reg[8], ready_q,
                           control_status_reg[6:1], 1'b0};                  // [R10] [R11]

  // Read mux: one address serves two registers in turn
  wire [15:0] rd_value =
    (host_req.index == REG_COUNT)   ? transfer_count_reg :                   // [R1]
    (hit_addr && second_read)       ? {10'h000, upper_address_reg} :         // [R19]
    hit_addr                        ? {memory_address, 1'b0} :               // [R5]
    (host_req.index == REG_CONTROL) ? ctrl_view :
    (host_req.index == REG_DATA)    ? input_capture :                        // [R15]
                                      16'h0000;

  always_ff @(posedge clk)
  begin
    if (rst)
      host_rdata <= 16'h0000;
    else if (rd_any)
      host_rdata <= rd_value;
  end

  // Alternating read pointer, only meaningful in 22-bit mode
  always_ff @(posedge clk)
  begin
    if (rst)
      second_read <= 1'b0;
    else if (rd_addr && addr22_mode)
      second_read <= !second_read;                                           // [R19]
    else if (!addr22_mode || (wr_any && !hit_addr))
      second_read <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      transfer_count_reg <= COUNT_RESET;
    else if (wr_count)
      transfer_count_reg <= host_req.wdata;                                  // [R1]
    else if (cnt_step)
      transfer_count_reg <= count_next;                                      // [R2]
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      memory_address <= ADDRESS_RESET;
    else if (wr_addr)
      memory_address <= host_req.wdata[15:1];                                // [R5]
    else if (adr_step)
      memory_address <= addr_sum[14:0];                                      // [R6]
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      upper_address_reg <= UPPER_RESET;
    else if (wr_upper)
      upper_address_reg <= host_req.wdata[5:0];                              // [R9]
    else if (addr_carry && addr22_mode)
      upper_address_reg <= upper_address_reg + 6'h01;                        // [R7]
  end

  // Stored control bits; attention, status and ready are supplied live in the view
  wire [15:0] ctrl_written = (control_status_reg & ~ctrl_wm) | (host_req.wdata & ctrl_wm);
  always_ff @(posedge clk)
  begin
    if (rst)
      control_status_reg <= CONTROL_RESET;
    else
    begin
      if (wr_ctrl)
        control_status_reg <= ctrl_written;                                  // [R11] [R14]
      if (wr_ctrl && host_req.byte_en[1] && !host_req.wdata[CS_NXM])
        control_status_reg[CS_NXM] <= 1'b0;                                  // [R12]
      if (addr_carry && !addr22_mode)
        control_status_reg[CS_XA_HI:CS_XA_LO] <= xa_next;                    // [R7] [R8]
      if (go_write || req_edge)
        control_status_reg[CS_ERROR] <= control_status_reg[CS_NXM];
    end
  end

  // Transfer state: go arms, zero count or attention stops and readies
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      active  <= 1'b0;
      ready_q <= 1'b1;
      irq_q   <= 1'b0;
    end
    else if (count_zero || (active && attn_stop))
    begin
      active  <= 1'b0;                                                       // [R3]
      ready_q <= 1'b1;
      irq_q   <= control_status_reg[CS_IE];
    end
    else if (go_write)
    begin
      active  <= 1'b1;
      ready_q <= 1'b0;
      irq_q   <= 1'b0;
    end
    else if (wr_ctrl && host_req.byte_en[0] && !host_req.wdata[CS_IE])
      irq_q <= 1'b0;
  end

  // One request per rising edge; an edge while memory FIFO is full raises none
  always_ff @(posedge clk)
  begin
    if (rst)
      req_q <= 1'b0;
    // Attention drops the request with active, so it never outlives ready
    else if (!active || xfer || attn_stop)
      req_q <= 1'b0;
    else if (req_edge && fifo_in_ready)
      req_q <= 1'b1;                                                         // [R20]
  end

  // Data buffers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      data_buffer_reg <= DATA_RESET;
      input_capture   <= DATA_RESET;
    end
    else
    begin
      if (wr_data)
        data_buffer_reg <= (data_buffer_reg & ~lane_mask)
                           | (host_req.wdata & lane_mask);                   // [R16] [R17]
      else if (xfer && !dma_to_memory)
        data_buffer_reg <= dma_rdata;                                        // [R16]
      if (req_edge)
        input_capture <= in_sync2;                                           // [R15] [R18]
    end
  end

  assign user_data_out = data_buffer_reg;                                    // [R18]
  assign user_function = control_status_reg[3:1];
  assign ready_out     = ready_q;
  assign irq           = irq_q;
  assign dma_req       = req_q;

  wire unused_ok = &{1'b0, fifo_word, count_next[0]};
endmodule

// ==== logic/dma_regs_pkg.sv ====
// Package: register indices, field positions, reset values and bus carriers
package dma_regs_pkg;

  // Register word indices on the host port (no offsets printed; chosen here)
  localparam logic [2:0] REG_COUNT   = 3'h0;
  localparam logic [2:0] REG_ADDRESS = 3'h1;
  localparam logic [2:0] REG_CONTROL = 3'h2;
  localparam logic [2:0] REG_DATA    = 3'h3;

  // Control/status field positions
  localparam int CS_GO      = 0;
  localparam int CS_FUNC_LO = 1;
  localparam int CS_XA_LO   = 4;
  localparam int CS_XA_HI   = 5;
  localparam int CS_IE      = 6;
  localparam int CS_READY   = 7;
  localparam int CS_CYCLE   = 8;
  localparam int CS_STAT_LO = 9;
  localparam int CS_MAINT   = 12;
  localparam int CS_ATTN    = 13;
  localparam int CS_NXM     = 14;
  localparam int CS_ERROR   = 15;

  // Writable bits and bits cleared by writing zero
  localparam logic [15:0] CS_RW_MASK    = 16'h117E;
  localparam logic [15:0] CS_XA_MASK    = 16'h0030;
  localparam logic [15:0] CS_W0C_MASK   = 16'h4000;

  // Reset values
  localparam logic [15:0] COUNT_RESET   = 16'h0000;
  localparam logic [14:0] ADDRESS_RESET = 15'h0000;
  localparam logic [5:0]  UPPER_RESET   = 6'h00;
  localparam logic [15:0] CONTROL_RESET = 16'h0080;
  localparam logic [15:0] DATA_RESET    = 16'h0000;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [2:0]  index;
    logic [1:0]  byte_en;
    logic [15:0] wdata;
  } host_req_s;

  typedef struct packed {
    logic [21:0] addr;
    logic [15:0] data;
  } mem_word_s;

endpackage

// ==== logic/word_fifo.sv ====
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/1ps
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  input  wire logic             clk,     // System clock
  input  wire logic             rst,     // Synchronous reset
  input  wire logic             in_valid, // Writer has a word
  output logic                  in_ready, // Room for a word
  input  wire logic [WIDTH-1:0] in_data, // Word written
  output logic                  out_valid, // Word available
  input  wire logic             out_ready, // Reader takes word
  output logic      [WIDTH-1:0] out_data // Head word
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      fill;

  wire push = in_valid && in_ready;
  wire pop  = out_valid && out_ready;

  assign in_ready  = (fill < (AW+1)'(DEPTH));
  assign out_valid = (fill != '0);
  assign out_data  = store[rd_ptr];

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fill   <= '0;
    end
    else
    begin
      if (push)
      begin
        store[wr_ptr] <= in_data;
        wr_ptr        <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
        rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
      fill <= fill + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule

// ==== verification/dma_regs_monitor.sv ====
// Concurrent checks on the DMA register block ports
`timescale 1ns/1ps
module dma_regs_monitor
  import dma_regs_pkg::*;
#(
  parameter int FIFO_DEPTH = 4
) (
  input wire logic                    clk,           // System clock
  input wire logic                    rst,           // Bus initialise
  input wire dma_regs_pkg::host_req_s host_req,      // Host register access
  input wire logic             [15:0] host_rdata,    // Read data
  input wire logic              [2:0] user_function, // Function lines
  input wire logic             [15:0] user_data_out, // Output connector data
  input wire logic                    ready_out,     // Ready flag
  input wire logic                    irq,           // Interrupt request level
  input wire logic                    dma_req,       // DMA request pending
  input wire logic                    dma_done,      // Bus finished one transfer
  input wire dma_regs_pkg::mem_word_s mem_out,       // Address/data to memory
  input wire logic                    mem_out_valid, // Memory write word ready
  input wire logic                    mem_out_ready  // Memory side accepts
);
  import dma_regs_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  wire ctl_rd = host_req.rd && (host_req.index == REG_CONTROL);
  wire ctl_wr = host_req.wr && (host_req.index == REG_CONTROL) && host_req.byte_en[0];
  wire obuf_wr = host_req.wr && (host_req.index == REG_DATA) && (host_req.byte_en == 2'b11);

  a_go_reads_zero: assert property (ctl_rd |=> host_rdata[CS_GO] == 1'b0)
    else $error("control bit 0 read back as one");
  a_irq_needs_ready: assert property (irq |-> ready_out)
    else $error("interrupt raised while not ready");
  a_req_while_busy: assert property (dma_req |-> !ready_out)
    else $error("request raised while ready");
  a_req_one_shot: assert property (dma_req && dma_done |=> !dma_req)
    else $error("request stayed up after its transfer");
  a_func_follows: assert property (ctl_wr |=> user_function == $past(host_req.wdata[3:1]))
    else $error("function lines did not follow control write");
  a_obuf_load: assert property (obuf_wr |=> user_data_out == $past(host_req.wdata))
    else $error("output buffer not loaded by host write");
  a_word_even: assert property (mem_out_valid |-> mem_out.addr[0] == 1'b0)
    else $error("word address with bit zero set");
  a_fifo_holds: assert property (mem_out_valid && !mem_out_ready |=> mem_out_valid && $stable(mem_out))
    else $error("memory word changed while stalled");
  a_unmapped_zero: assert property (host_req.rd && host_req.index > REG_DATA |=> host_rdata == 16'h0000)
    else $error("unmapped read returned nonzero");

  c_transfer: cover property (dma_req && dma_done);
  c_drain: cover property (mem_out_valid && mem_out_ready);
  c_irq: cover property ($rose(irq));
endmodule

bind dma_transfer_registers dma_regs_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) u_dma_regs_monitor (
  .clk(clk), .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
  .user_function(user_function), .user_data_out(user_data_out), .ready_out(ready_out),
  .irq(irq), .dma_req(dma_req), .dma_done(dma_done), .mem_out(mem_out),
  .mem_out_valid(mem_out_valid), .mem_out_ready(mem_out_ready));

// ==== verification/mem_bus_model.sv ====
// Memory side model: answers DMA requests and drains the write FIFO
`timescale 1ns/1ps
module mem_bus_model (
  input  wire logic        clk,       // System clock
  input  wire logic        rst,       // Synchronous reset
  input  wire logic        dma_req,   // Request from block
  input  wire logic        stall,     // Bench holds the drain side off
  output logic             dma_done,  // One transfer finished
  output logic      [15:0] dma_rdata, // Word read from memory
  output logic             mem_ready  // Drain side accepts
);
  logic [2:0] wait_cnt;
  initial
  begin
    dma_done  = 1'b0;
    dma_rdata = 16'h0000;
    mem_ready = 1'b0;
    wait_cnt  = 3'h0;
  end
  always @(negedge clk)
  begin
    mem_ready <= !stall && ($urandom_range(0, 2) != 0);  // Random stalls on the drain side
    if (rst || !dma_req || dma_done)
    begin
      dma_done  <= 1'b0;
      dma_rdata <= ~dma_rdata;  // Not held outside the answer cycle
      wait_cnt  <= 3'($urandom_range(0, 4));  // Prompt or slow answer
    end
    else if (wait_cnt != 3'h0)
    begin
      dma_done  <= 1'b0;
      dma_rdata <= ~dma_rdata;
      wait_cnt  <= wait_cnt - 3'h1;
    end
    else
    begin
      dma_done  <= 1'b1;
      dma_rdata <= 16'($urandom);
    end
  end
endmodule

// ==== verification/testbench.sv ====
// Self-checking bench for the DMA register block
`timescale 1ns/1ps
module testbench;
  import dma_regs_pkg::*;
  typedef struct { string name; logic [15:0] mask; logic [15:0] value; } note_s;
  logic        clk, rst, addr22_mode, cycle_request, dma_to_memory, stall, cnt_allow, adr_allow;
  logic        dma_done, mem_out_valid, mem_out_ready, ready_out, irq, dma_req;
  logic [15:0] host_rdata, user_data_in, user_data_out, dma_rdata, last_mem, wv;
  logic  [2:0] user_status, user_function;
  host_req_s   host_req;
  mem_word_s   mem_out, m;
  note_s       note;
  note_s       rd_q[$];
  mem_word_s   mem_q[$];
  int          n_errors, n_compared, n_done, d0;

  dma_transfer_registers #(.FIFO_DEPTH(4)) u_dma_transfer_registers (
    .clk(clk), .rst(rst), .host_req(host_req), .host_rdata(host_rdata),
    .addr22_mode(addr22_mode), .addr16_system(1'b0), .user_data_in(user_data_in),
    .user_status(user_status), .user_attention(1'b0), .cycle_request(cycle_request),
    .count_advance_allow(cnt_allow), .address_advance_allow(adr_allow),
    .dma_to_memory(dma_to_memory), .user_data_out(user_data_out),
    .user_function(user_function), .ready_out(ready_out), .irq(irq), .dma_req(dma_req),
    .dma_done(dma_done), .dma_rdata(dma_rdata), .mem_out(mem_out),
    .mem_out_valid(mem_out_valid), .mem_out_ready(mem_out_ready));
  mem_bus_model u_mem_bus_model (
    .clk(clk), .rst(rst), .dma_req(dma_req), .stall(stall), .dma_done(dma_done),
    .dma_rdata(dma_rdata), .mem_ready(mem_out_ready));

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic check(input string what, input logic [21:0] seen, input logic [21:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %0s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic access(input logic wr, input logic [2:0] idx, input logic [1:0] be,
                        input logic [15:0] d);
    @(negedge clk);
    host_req <= '{rd: !wr, wr: wr, index: idx, byte_en: be, wdata: d};
    @(negedge clk);
    host_req <= '0;
  endtask

  task automatic rd(input string what, input logic [2:0] idx, input logic [15:0] mask,
                    input logic [15:0] exp);
    rd_q.push_back('{name: what, mask: mask, value: exp});
    access(1'b0, idx, 2'b11, 16'h0000);
  endtask

  // Waits for the transfer, bounded: a full FIFO may refuse it
  task automatic request_word(input logic [15:0] word);
    int start;
    start = n_done;
    @(negedge clk);
    user_data_in  <= word;
    cycle_request <= 1'b1;
    for (int i = 0; i < 20 && n_done == start; i++)
      @(negedge clk);
    cycle_request <= 1'b0;
    user_data_in  <= ~word;
    repeat (3) @(negedge clk);
  endtask

  task automatic do_reset(input logic mode22);
    @(negedge clk);
    rst         <= 1'b1;
    addr22_mode <= mode22;
    repeat (6) @(negedge clk);
    rst <= 1'b0;
  endtask

  task automatic wrap_up;
    $display("Compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk)
    if (host_req.rd && !rst)
    begin
      @(negedge clk);
      note = rd_q.pop_front();
      check(note.name, 22'(host_rdata & note.mask), 22'(note.value & note.mask));
    end

  always @(posedge clk)
  begin
    if (dma_done && dma_req)
    begin
      n_done   <= n_done + 1;
      last_mem <= dma_rdata;
    end
    if (mem_out_valid && mem_out_ready && !rst)
    begin
      m = mem_q.pop_front();
      check("mem addr", mem_out.addr, m.addr);
      check("mem data", 22'(mem_out.data), 22'(m.data));
    end
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("[ERR] watchdog expected finish seen hang");
    wrap_up();
  end

  initial
  begin
    void'($urandom(32'h1EA9));
    rst = 1'b1; addr22_mode = 1'b0; cycle_request = 1'b0; dma_to_memory = 1'b1;
    stall = 1'b0; host_req = '0; user_data_in = 16'h0000; n_done = 0;
    cnt_allow = 1'b1;
    adr_allow = 1'b1;
    user_status = 3'($urandom);
    n_errors = 0; n_compared = 0;
    do_reset(1'b0);
    // Reset values, access kinds, byte lanes, shared data address
    rd("count reset", REG_COUNT, 16'hFFFF, COUNT_RESET);
    rd("address reset", REG_ADDRESS, 16'hFFFE, 16'h0000);
    rd("control reset", REG_CONTROL, 16'hFFFF, CONTROL_RESET | {4'h0, user_status, 9'h000});
    rd("unmapped", 3'h5, 16'hFFFF, 16'h0000);
    wv = 16'($urandom);
    access(1'b1, REG_COUNT, 2'b11, wv);
    access(1'b1, REG_COUNT, 2'b01, ~wv);
    rd("count byte refused", REG_COUNT, 16'hFFFF, wv);
    wv = 16'($urandom);
    access(1'b1, REG_ADDRESS, 2'b11, wv);
    rd("address rw", REG_ADDRESS, 16'hFFFE, wv);
    wv = 16'($urandom) & 16'hFEFE;
    access(1'b1, REG_CONTROL, 2'b11, wv);
    rd("control word", REG_CONTROL, 16'hFFFF, (wv & CS_RW_MASK) | 16'h0080 | {4'h0, user_status, 9'h000});
    access(1'b1, REG_CONTROL, 2'b10, 16'h0000);
    rd("control byte", REG_CONTROL, 16'hFFFF, (wv & 16'h007E) | 16'h0080 | {4'h0, user_status, 9'h000});
    wv = 16'($urandom);
    access(1'b1, REG_DATA, 2'b11, wv);
    check("output buffer", 22'(user_data_out), 22'(wv));
    rd("input buffer", REG_DATA, 16'hFFFF, DATA_RESET);
    $display("Test registers finished, errors %0d", n_errors);
    // Wide addressing: read-only extension bits, alternating reads
    do_reset(1'b1);
    access(1'b1, REG_CONTROL, 2'b11, 16'h0030);
    rd("ext bits locked", REG_CONTROL, 16'h0030, 16'h0000);
    wv = 16'($urandom);
    access(1'b1, REG_ADDRESS, 2'b11, wv);
    rd("address first", REG_ADDRESS, 16'hFFFE, wv);
    rd("upper second", REG_ADDRESS, 16'h003F, 16'(UPPER_RESET));
    $display("Test wide mode finished, errors %0d", n_errors);
    // Device to memory across a 32K word carry, FIFO filled while stalled
    do_reset(1'b0);
    stall <= 1'b1;
    access(1'b1, REG_COUNT, 2'b11, 16'hFFFB);
    access(1'b1, REG_ADDRESS, 2'b11, 16'hFFFC);
    access(1'b1, REG_CONTROL, 2'b11, 16'h0001);
    d0 = n_done;
    for (int i = 0; i < 5; i++)
    begin
      wv = 16'($urandom);
      mem_q.push_back('{addr: 22'h00FFFC + 22'(2 * i), data: wv});
      request_word(wv);
    end
    check("full fifo refuses", 22'(n_done - d0), 22'd4);
    stall <= 1'b0;
    for (int i = 0; i < 80 && mem_q.size() > 0; i++)
      @(negedge clk);
    check("fifo drained", 22'(mem_q.size()), 22'd1);
    rd("carry into ext bits", REG_CONTROL, 16'h0030, 16'h0010);
    $display("Test device to memory finished, errors %0d", n_errors);
    // Memory to device, last word ends the run
    do_reset(1'b0);
    mem_q.delete();
    dma_to_memory <= 1'b0;
    access(1'b1, REG_COUNT, 2'b11, 16'hFFFF);
    access(1'b1, REG_ADDRESS, 2'b11, 16'h0010);
    access(1'b1, REG_CONTROL, 2'b11, 16'h0041);
    // First transfer with both advance inputs low: nothing may step
    cnt_allow <= 1'b0;
    adr_allow <= 1'b0;
    request_word(16'($urandom));
    rd("count held", REG_COUNT, 16'hFFFF, 16'hFFFF);
    rd("address held", REG_ADDRESS, 16'hFFFE, 16'h0010);
    cnt_allow <= 1'b1;
    adr_allow <= 1'b1;
    request_word(16'($urandom));
    check("output from memory", 22'(user_data_out), 22'(last_mem));
    check("ready at zero", 22'(ready_out), 22'd1);
    check("irq at zero", 22'(irq), 22'd1);
    rd("count at zero", REG_COUNT, 16'hFFFF, 16'h0000);
    rd("address stepped", REG_ADDRESS, 16'hFFFE, 16'h0012);
    repeat (3) @(negedge clk);
    $display("Test memory to device finished, errors %0d", n_errors);
    wrap_up();
  end
endmodule
